// ===== logic/wtx_reg_bank.sv
`include "wtx_consts.svh"

module wtx_reg_bank (
    input wire logic sys_clk_i, // 25 MHz system clock
    input wire logic nrst_i, // asynchronous reset, active low
    input wire logic [`WTX_ADDR_W-1:0] addr_i, // register byte address
    input wire logic [`WTX_DATA_W-1:0] wdata_i, // write data
    input wire logic wr_i, // write strobe
    input wire logic rd_i, // read strobe
    output logic [`WTX_DATA_W-1:0] rdata_o, // read data, cycle after rd_i
    input wire logic [`WTX_DATA_W-1:0] input_voltage_reading_i, // measured input, mV
    input wire logic [`WTX_DATA_W-1:0] rectified_voltage_reading_i, // measured rectified, mV
    input wire logic [`WTX_DATA_W-1:0] rx_power_i, // received power estimate, mW
    input wire logic [`WTX_DATA_W-1:0] stored_command_i, // stored command word
    input wire logic ping_overcurrent_i, // overcurrent during digital ping
    input wire logic bit6_overcurrent_i, // overcurrent, upper reason
    input wire logic foreign_object_i, // foreign object error
    input wire logic undervoltage_i, // rectified below low limit
    input wire logic overvoltage_i, // overvoltage error
    input wire logic overcurrent_i, // overcurrent error
    input wire logic cep_timeout_i, // control error packet timeout
    input wire logic watchdog_expiry_i, // watchdog ended transfer
    input wire logic end_packet_i, // end power packet received
    output logic tx_mode_o, // transmit mode active
    output logic int_clear_o, // one-cycle clear of pending interrupt
    output logic prop_packet_send_o, // one-cycle proprietary packet request
    output logic stored_command_go_o, // one-cycle run of stored command
    output logic [`WTX_DATA_W-1:0] stored_command_o, // fetched stored command
    output logic [`WTX_DATA_W-1:0] overvoltage_limit_o, // live overvoltage limit
    output logic [`WTX_DATA_W-1:0] overcurrent_limit_o, // live overcurrent limit
    output logic [`WTX_DATA_W-1:0] fod_limit_o // selected foreign object limit
);

    wtx_pkg::wtx_state_t s_q;
    wtx_pkg::wtx_state_t s_d;
    logic [`WTX_EVT_N-1:0] evt_pins;
    logic [`WTX_DATA_W-1:0] reason_set;
    logic [`WTX_DATA_W-1:0] reason_clr;
    logic [`WTX_DATA_W-1:0] cmd_set;

    // lowest set bit as a one-hot word, so commands run in a fixed order
    function automatic logic [`WTX_DATA_W-1:0] lowest_bit(input logic [`WTX_DATA_W-1:0] v);
        lowest_bit = v & (~v + 16'h0001);
    endfunction : lowest_bit

    // exact even-address decode used by the write paths; the read mux decodes addr_i itself
    function automatic logic hit(input logic [`WTX_ADDR_W-1:0] a, input logic [`WTX_ADDR_W-1:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    // event pins come from the power stage, outside this clock
    assign evt_pins = {end_packet_i, watchdog_expiry_i, cep_timeout_i, overcurrent_i, overvoltage_i,
                       undervoltage_i, foreign_object_i, bit6_overcurrent_i, ping_overcurrent_i};

    // reason bits fed from the second sync stage only
    // ping overcurrent
    always_comb begin
        reason_set = 16'h0000;
        reason_set[`WTX_RSN_PING_OC] = s_q.sync2[0];
        reason_set[`WTX_RSN_BIT6_OC] = s_q.sync2[1];
        reason_set[`WTX_RSN_FOREIGN_OBJ] = s_q.sync2[2];
        reason_set[`WTX_RSN_UNDERVOLTAGE] = s_q.sync2[3];
        reason_set[`WTX_RSN_OVERVOLTAGE] = s_q.sync2[4];
        reason_set[`WTX_RSN_OVERCURRENT] = s_q.sync2[5];
        reason_set[`WTX_RSN_CEP_TIMEOUT] = s_q.sync2[6];
        reason_set[`WTX_RSN_WATCHDOG] = s_q.sync2[7];
        reason_set[`WTX_RSN_END_PACKET] = s_q.sync2[8];
    end

    // a new transmit session starts with a clean reason word
    assign reason_clr = (s_q.state == wtx_pkg::wtx_st_issue && s_q.cmd_cur[`WTX_CMD_TX_ENABLE]) ?
                        16'hFFFF : 16'h0000;

    // host command writes; reserved bits never latch
    assign cmd_set = (wr_i && hit(addr_i, `WTX_OFS_SYS_COMMAND)) ? (wdata_i & `WTX_CMD_MASK) : 16'h0000;

    // next-state logic for the whole bank
    always_comb begin
        s_d = s_q;
        s_d.sync1 = evt_pins;
        s_d.sync2 = s_q.sync1;
        s_d.int_clear = 1'b0;
        s_d.prop_send = 1'b0;
        s_d.stored_go = 1'b0;
        s_d.rdata = 16'h0000;

        // sticky flags, an event in the clearing cycle survives
        // reserved bits zero
        s_d.reason = ((s_q.reason & ~reason_clr) | reason_set) & `WTX_RSN_MASK;

        // threshold registers
        // overvoltage limit
        if (wr_i && hit(addr_i, `WTX_OFS_OV_LIMIT)) begin
            s_d.ov_limit = wdata_i;
        end
        if (wr_i && hit(addr_i, `WTX_OFS_OC_LIMIT)) begin
            s_d.oc_limit = wdata_i;
        end
        if (wr_i && hit(addr_i, `WTX_OFS_FOD_LOW)) begin
            s_d.fod_low = wdata_i;
        end
        if (wr_i && hit(addr_i, `WTX_OFS_FOD_HIGH)) begin
            s_d.fod_high = wdata_i;
        end
        if (wr_i && hit(addr_i, `WTX_OFS_FOD_SPLIT)) begin
            s_d.fod_split = wdata_i;
        end

        s_d.fod_limit = (rx_power_i > s_q.fod_split) ? s_q.fod_high : s_q.fod_low;

        // command engine: one bit per pass, lowest bit first
        s_d.cmd_pend = s_q.cmd_pend | cmd_set;
        unique case (s_q.state)
            wtx_pkg::wtx_st_idle: begin
                if (s_q.cmd_pend != 16'h0000) begin
                    s_d.cmd_cur = lowest_bit(s_q.cmd_pend);
                    s_d.state = wtx_pkg::wtx_st_issue;
                end
            end
            wtx_pkg::wtx_st_issue: begin
                if (s_q.cmd_cur[`WTX_CMD_TX_ENABLE]) begin
                    s_d.tx_mode = 1'b1;
                end
                if (s_q.cmd_cur[`WTX_CMD_TX_DISABLE]) begin
                    s_d.tx_mode = 1'b0;
                end
                s_d.prop_send = s_q.cmd_cur[`WTX_CMD_PROP_PACKET];
                s_d.int_clear = s_q.cmd_cur[`WTX_CMD_INT_CLEAR];
                if (s_q.cmd_cur[`WTX_CMD_RUN_STORED]) begin
                    s_d.stored_cmd = stored_command_i;
                    s_d.stored_go = 1'b1;
                end
                s_d.state = wtx_pkg::wtx_st_retire;
            end
            wtx_pkg::wtx_st_retire: begin
                s_d.cmd_pend = (s_q.cmd_pend & ~s_q.cmd_cur) | cmd_set;
                s_d.cmd_cur = 16'h0000;
                s_d.state = wtx_pkg::wtx_st_idle;
            end
            default: begin
                // recover from a corrupted one-hot code
                s_d.state = wtx_pkg::wtx_st_idle;
                s_d.cmd_cur = 16'h0000;
            end
        endcase

        // read mux, data stand for one cycle only
        if (rd_i) begin
            unique case (addr_i)
                `WTX_OFS_INPUT_VOLTAGE: s_d.rdata = input_voltage_reading_i;
                `WTX_OFS_RECT_VOLTAGE: s_d.rdata = rectified_voltage_reading_i;
                `WTX_OFS_END_REASON: s_d.rdata = s_q.reason;
                `WTX_OFS_SYS_COMMAND: s_d.rdata = s_q.cmd_pend;
                `WTX_OFS_OV_LIMIT: s_d.rdata = s_q.ov_limit;
                `WTX_OFS_OC_LIMIT: s_d.rdata = s_q.oc_limit;
                `WTX_OFS_FOD_LOW: s_d.rdata = s_q.fod_low;
                `WTX_OFS_FOD_HIGH: s_d.rdata = s_q.fod_high;
                `WTX_OFS_FOD_SPLIT: s_d.rdata = s_q.fod_split;
                default: s_d.rdata = 16'h0000;
            endcase
        end
    end

    // state register; reset loads constants only
    // commands reset to zero
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s_q.sync1 <= '0;
            s_q.sync2 <= '0;
            s_q.reason <= 16'h0000;
            s_q.ov_limit <= `WTX_RST_OV_LIMIT;
            s_q.oc_limit <= `WTX_RST_OC_LIMIT;
            s_q.fod_low <= `WTX_RST_FOD_LOW;
            s_q.fod_high <= `WTX_RST_FOD_HIGH;
            s_q.fod_split <= `WTX_RST_FOD_SPLIT;
            s_q.cmd_pend <= 16'h0000;
            s_q.cmd_cur <= 16'h0000;
            s_q.state <= wtx_pkg::wtx_st_idle;
            s_q.tx_mode <= 1'b0;
            s_q.int_clear <= 1'b0;
            s_q.prop_send <= 1'b0;
            s_q.stored_go <= 1'b0;
            s_q.stored_cmd <= 16'h0000;
            s_q.fod_limit <= `WTX_RST_FOD_LOW;
            s_q.rdata <= 16'h0000;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from the state register
    assign rdata_o = s_q.rdata;
    assign tx_mode_o = s_q.tx_mode;
    assign int_clear_o = s_q.int_clear;
    assign prop_packet_send_o = s_q.prop_send;
    assign stored_command_go_o = s_q.stored_go;
    assign stored_command_o = s_q.stored_cmd;
    assign overvoltage_limit_o = s_q.ov_limit;
    assign overcurrent_limit_o = s_q.oc_limit;
    assign fod_limit_o = s_q.fod_limit;

    // checks on the bank's own behaviour

    property p_input_voltage;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (rd_i && addr_i == `WTX_OFS_INPUT_VOLTAGE) |=> (rdata_o == $past(input_voltage_reading_i));
    endproperty
    a_input_voltage: assert property (p_input_voltage) else $error("input voltage read wrong");

    property p_rect_voltage;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (rd_i && addr_i == `WTX_OFS_RECT_VOLTAGE) |=> (rdata_o == $past(rectified_voltage_reading_i));
    endproperty
    a_rect_voltage: assert property (p_rect_voltage) else $error("rectified voltage read wrong");

    property p_ping_oc;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        ping_overcurrent_i |-> ##3 s_q.reason[`WTX_RSN_PING_OC];
    endproperty
    a_ping_oc: assert property (p_ping_oc) else $error("ping overcurrent flag not set");

    property p_fod_flag;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        foreign_object_i |-> ##3 s_q.reason[`WTX_RSN_FOREIGN_OBJ];
    endproperty
    a_fod_flag: assert property (p_fod_flag) else $error("foreign object flag not set");

    property p_uv_flag;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        undervoltage_i |-> ##3 s_q.reason[`WTX_RSN_UNDERVOLTAGE];
    endproperty
    a_uv_flag: assert property (p_uv_flag) else $error("undervoltage flag not set");

    property p_ov_flag;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        overvoltage_i |-> ##3 s_q.reason[`WTX_RSN_OVERVOLTAGE];
    endproperty
    a_ov_flag: assert property (p_ov_flag) else $error("overvoltage flag not set");

    property p_oc_flags;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        overcurrent_i |-> ##3 s_q.reason[`WTX_RSN_OVERCURRENT];
    endproperty
    a_oc_flags: assert property (p_oc_flags) else $error("overcurrent flag not set");

    property p_bit6_oc;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        bit6_overcurrent_i |-> ##3 s_q.reason[`WTX_RSN_BIT6_OC];
    endproperty
    a_bit6_oc: assert property (p_bit6_oc) else $error("upper overcurrent flag not set");

    property p_timeouts;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        cep_timeout_i |-> ##3 s_q.reason[`WTX_RSN_CEP_TIMEOUT];
    endproperty
    a_timeouts: assert property (p_timeouts) else $error("control error timeout flag not set");

    property p_watchdog;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        watchdog_expiry_i |-> ##3 s_q.reason[`WTX_RSN_WATCHDOG];
    endproperty
    a_watchdog: assert property (p_watchdog) else $error("watchdog flag not set");

    property p_end_packet;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        end_packet_i |-> ##3 s_q.reason[`WTX_RSN_END_PACKET];
    endproperty
    a_end_packet: assert property (p_end_packet) else $error("end packet flag not set");

    property p_stored_run;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (s_q.state == wtx_pkg::wtx_st_issue && s_q.cmd_cur[`WTX_CMD_RUN_STORED]) |=>
        (stored_command_go_o && stored_command_o == $past(stored_command_i));
    endproperty
    a_stored_run: assert property (p_stored_run) else $error("stored command not fetched");

    property p_int_clear;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        int_clear_o |-> ($past(s_q.cmd_cur[`WTX_CMD_INT_CLEAR]) && $past(s_q.state) == wtx_pkg::wtx_st_issue);
    endproperty
    a_int_clear: assert property (p_int_clear) else $error("interrupt clear without command");

    property p_prop_send;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        prop_packet_send_o |-> ($past(s_q.cmd_cur[`WTX_CMD_PROP_PACKET]) && $past(s_q.state) == wtx_pkg::wtx_st_issue);
    endproperty
    a_prop_send: assert property (p_prop_send) else $error("packet request without command");

    property p_tx_enable;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (wr_i && addr_i == `WTX_OFS_SYS_COMMAND && wdata_i == 16'h0001 && s_q.cmd_pend == 16'h0000 &&
         s_q.state == wtx_pkg::wtx_st_idle) |-> ##3 tx_mode_o ##1 (s_q.cmd_pend[`WTX_CMD_TX_ENABLE] == 1'b0);
    endproperty
    a_tx_enable: assert property (p_tx_enable) else $error("enable command not honoured");

    property p_tx_disable;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (s_q.state == wtx_pkg::wtx_st_issue && s_q.cmd_cur[`WTX_CMD_TX_DISABLE]) |=> !tx_mode_o;
    endproperty
    a_tx_disable: assert property (p_tx_disable) else $error("disable command not honoured");

    property p_ov_write;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (wr_i && addr_i == `WTX_OFS_OV_LIMIT) |=> (overvoltage_limit_o == $past(wdata_i));
    endproperty
    a_ov_write: assert property (p_ov_write) else $error("overvoltage limit not written");

    property p_fod_select;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        ($past(nrst_i) && $past(rx_power_i) > $past(s_q.fod_split)) |-> (fod_limit_o == $past(s_q.fod_high));
    endproperty
    a_fod_select: assert property (p_fod_select) else $error("high segment limit not chosen");

    property p_reason_reserved;
        @(posedge sys_clk_i) disable iff (!nrst_i)
        (rd_i && addr_i == `WTX_OFS_END_REASON) |=> ((rdata_o & ~`WTX_RSN_MASK) == 16'h0000);
    endproperty
    a_reason_reserved: assert property (p_reason_reserved) else $error("reserved reason bits set");

endmodule : wtx_reg_bank

// ===== logic/wtx_consts.svh
`ifndef WTX_CONSTS_SVH
`define WTX_CONSTS_SVH

// bus geometry
`define WTX_ADDR_W 8
`define WTX_DATA_W 16

// register byte offsets
`define WTX_OFS_INPUT_VOLTAGE 8'h70
`define WTX_OFS_RECT_VOLTAGE 8'h72
`define WTX_OFS_END_REASON 8'h74
`define WTX_OFS_SYS_COMMAND 8'h76
`define WTX_OFS_OV_LIMIT 8'h98
`define WTX_OFS_OC_LIMIT 8'h9A
`define WTX_OFS_FOD_LOW 8'hA8
`define WTX_OFS_FOD_HIGH 8'hAA
`define WTX_OFS_FOD_SPLIT 8'hAC

// reset values
`define WTX_RST_OV_LIMIT 16'h2AF8
`define WTX_RST_OC_LIMIT 16'h05DC
`define WTX_RST_FOD_LOW 16'h0320
`define WTX_RST_FOD_HIGH 16'hFF9C
`define WTX_RST_FOD_SPLIT 16'h0E74

// end reason bits, low byte at the lower address
`define WTX_RSN_END_PACKET 0
`define WTX_RSN_WATCHDOG 7
`define WTX_RSN_CEP_TIMEOUT 8
`define WTX_RSN_OVERCURRENT 10
`define WTX_RSN_OVERVOLTAGE 11
`define WTX_RSN_UNDERVOLTAGE 12
`define WTX_RSN_FOREIGN_OBJ 13
`define WTX_RSN_BIT6_OC 14
`define WTX_RSN_PING_OC 15
`define WTX_RSN_MASK 16'hFD81

// system command bits
`define WTX_CMD_TX_ENABLE 0
`define WTX_CMD_TX_DISABLE 2
`define WTX_CMD_PROP_PACKET 3
`define WTX_CMD_INT_CLEAR 5
`define WTX_CMD_RUN_STORED 6
`define WTX_CMD_MASK 16'h006D

// number of event pins
`define WTX_EVT_N 9

`endif

// ===== logic/wtx_pkg.sv
`include "wtx_consts.svh"

package wtx_pkg;

    // command engine states
    typedef enum logic [2:0] {
        wtx_st_idle = 3'b001,
        wtx_st_issue = 3'b010,
        wtx_st_retire = 3'b100
    } wtx_cmd_state_t;

    // whole state of the register bank
    typedef struct packed {
        logic [`WTX_EVT_N-1:0] sync1;
        logic [`WTX_EVT_N-1:0] sync2;
        logic [`WTX_DATA_W-1:0] reason;
        logic [`WTX_DATA_W-1:0] ov_limit;
        logic [`WTX_DATA_W-1:0] oc_limit;
        logic [`WTX_DATA_W-1:0] fod_low;
        logic [`WTX_DATA_W-1:0] fod_high;
        logic [`WTX_DATA_W-1:0] fod_split;
        logic [`WTX_DATA_W-1:0] cmd_pend;
        logic [`WTX_DATA_W-1:0] cmd_cur;
        wtx_cmd_state_t state;
        logic tx_mode;
        logic int_clear;
        logic prop_send;
        logic stored_go;
        logic [`WTX_DATA_W-1:0] stored_cmd;
        logic [`WTX_DATA_W-1:0] fod_limit;
        logic [`WTX_DATA_W-1:0] rdata;
    } wtx_state_t;

endpackage : wtx_pkg

// ===== test/wtx_host_model.sv
`include "wtx_consts.svh"

// host side of the register port, one bus cycle at a time
module wtx_host_model #(
    parameter int CMD_GAP_CYC = 8 // command spacing, cut down from milliseconds to keep runs short
) (
    input wire logic sys_clk_i, // bench clock
    input wire logic [`WTX_DATA_W-1:0] rdata_i, // read data from the bank
    output logic [`WTX_ADDR_W-1:0] addr_o, // byte address
    output logic [`WTX_DATA_W-1:0] wdata_o, // write data
    output logic wr_o, // write strobe
    output logic rd_o // read strobe
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus at time zero
    initial begin
        addr_o = 8'h00;
        wdata_o = 16'h0000;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // released lines show the inverse, so a stale value never looks valid
    task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge sys_clk_i);
        wr_o <= 1'b0;
        addr_o <= ~a;
        wdata_o <= ~d;
    endtask : write_reg

    // read data stand only in the cycle after the strobe
    task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
        @(posedge sys_clk_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge sys_clk_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
        #1;
        d = rdata_i;
    endtask : read_reg

    task automatic send_command(input logic [15:0] d);
        write_reg(8'h76, d);
        repeat (CMD_GAP_CYC) @(posedge sys_clk_i);
        #1;
    endtask : send_command

endmodule : wtx_host_model

// ===== test/wireless_tx_mode_register_bank_tb_top.sv
`include "wtx_consts.svh"

`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; $display("[FAIL] %0t ns: got %h expected %h", $time, (g), (e)); end end

module wireless_tx_mode_register_bank_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [7:0] addr;
    logic [15:0] wdata, rdata, stored_word, ov_lim, oc_lim, fod_lim;
    logic wr, rd, tx_mode, int_clear, prop_send, stored_go;
    logic [15:0] vin = 16'h1388;
    logic [15:0] vrect = 16'h1450;
    logic [15:0] rx_power = 16'h0000;
    logic [15:0] stored_cmd = 16'hA5C3;
    logic [8:0] evt = 9'h000;
    int errors = 0;
    int compares = 0;
    int cycles = 0;
    int n_clr = 0;
    int n_prop = 0;
    int n_go = 0;
    // reason bit reached by each event pin, in pin order
    int rsn_pos [9] = '{15, 14, 13, 12, 11, 10, 8, 7, 0};

    // 25 MHz clock
    always #20 sys_clk_i = ~sys_clk_i;

    wtx_reg_bank dut (
        .sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .rdata_o(rdata), .input_voltage_reading_i(vin), .rectified_voltage_reading_i(vrect),
        .rx_power_i(rx_power), .stored_command_i(stored_cmd), .ping_overcurrent_i(evt[0]),
        .bit6_overcurrent_i(evt[1]), .foreign_object_i(evt[2]), .undervoltage_i(evt[3]),
        .overvoltage_i(evt[4]), .overcurrent_i(evt[5]), .cep_timeout_i(evt[6]),
        .watchdog_expiry_i(evt[7]), .end_packet_i(evt[8]), .tx_mode_o(tx_mode), .int_clear_o(int_clear),
        .prop_packet_send_o(prop_send), .stored_command_go_o(stored_go), .stored_command_o(stored_word),
        .overvoltage_limit_o(ov_lim), .overcurrent_limit_o(oc_lim), .fod_limit_o(fod_lim)
    );

    wtx_host_model #(.CMD_GAP_CYC(8)) host (
        .sys_clk_i(sys_clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd)
    );

    // pulse outputs counted per high cycle, so a stretched pulse shows up
    always @(posedge sys_clk_i) begin
        n_clr += int'(int_clear === 1'b1);
        n_prop += int'(prop_send === 1'b1);
        n_go += int'(stored_go === 1'b1);
    end

    // hang guard
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            $display("[FAIL] %0t ns: timeout", $time);
            end_of_test();
        end
    end

    task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] v;
        host.read_reg(a, v);
        `CHK(v, e)
    endtask : chk_rd

    task automatic test_reset_values();
        chk_rd(8'h98, 16'h2AF8);
        chk_rd(8'h9A, 16'h05DC);
        chk_rd(8'hA8, 16'h0320);
        chk_rd(8'hAA, 16'hFF9C);
        chk_rd(8'h74, 16'h0000);
        chk_rd(8'h76, 16'h0000);
        `CHK(tx_mode, 1'b0)
        `CHK(fod_lim, 16'h0320)
        $display("test reset_values done");
    endtask : test_reset_values

    task automatic test_regs();
        chk_rd(8'h70, vin);
        chk_rd(8'h72, vrect);
        @(posedge sys_clk_i);
        #1;
        `CHK(rdata, 16'h0000)
        @(posedge sys_clk_i);
        vin <= 16'h0BB8;
        vrect <= 16'h0C80;
        chk_rd(8'h70, 16'h0BB8);
        chk_rd(8'h72, 16'h0C80);
        host.write_reg(8'h70, 16'h0000);
        host.write_reg(8'h74, 16'hFFFF);
        chk_rd(8'h70, vin);
        chk_rd(8'h74, 16'h0000);
        chk_rd(8'h75, 16'h0000);
        host.write_reg(8'h98, 16'h1234);
        host.write_reg(8'h9A, 16'h0ABC);
        host.write_reg(8'hA8, 16'h0400);
        host.write_reg(8'hAA, 16'h8001);
        chk_rd(8'h98, 16'h1234);
        chk_rd(8'h9A, 16'h0ABC);
        chk_rd(8'hA8, 16'h0400);
        chk_rd(8'hAA, 16'h8001);
        `CHK(ov_lim, 16'h1234)
        `CHK(oc_lim, 16'h0ABC)
        $display("test regs done");
    endtask : test_regs

    task automatic test_reasons();
        logic [15:0] exp;
        exp = 16'h0000;
        for (int i = 0; i < 9; i++) begin
            @(posedge sys_clk_i);
            evt[i] <= 1'b1;
            @(posedge sys_clk_i);
            evt[i] <= 1'b0;
            repeat (4) @(posedge sys_clk_i);
            exp[rsn_pos[i]] = 1'b1;
            chk_rd(8'h74, exp);
        end
        host.send_command(16'h0001);
        chk_rd(8'h74, 16'h0000);
        $display("test reasons done");
    endtask : test_reasons

    task automatic test_commands();
        `CHK(tx_mode, 1'b1)
        chk_rd(8'h76, 16'h0000);
        host.send_command(16'h0008);
        `CHK(n_prop, 1)
        host.send_command(16'h0020);
        `CHK(n_clr, 1)
        host.send_command(16'h0040);
        `CHK(n_go, 1)
        `CHK(stored_word, stored_cmd)
        @(posedge sys_clk_i);
        stored_cmd <= 16'h3C5A;
        host.send_command(16'h0040);
        `CHK(n_go, 2)
        `CHK(stored_word, 16'h3C5A)
        host.send_command(16'h0028);
        `CHK(n_prop, 2)
        `CHK(n_clr, 2)
        chk_rd(8'h76, 16'h0000);
        host.send_command(16'h0004);
        `CHK(tx_mode, 1'b0)
        host.send_command(16'hFF92);
        `CHK(tx_mode, 1'b0)
        `CHK(n_prop + n_clr + n_go, 6)
        chk_rd(8'h76, 16'h0000);
        $display("test commands done");
    endtask : test_commands

    task automatic test_fod();
        @(posedge sys_clk_i);
        rx_power <= 16'h0E74;
        repeat (2) @(posedge sys_clk_i);
        #1;
        `CHK(fod_lim, 16'h0400)
        @(posedge sys_clk_i);
        rx_power <= 16'h0E75;
        repeat (2) @(posedge sys_clk_i);
        #1;
        `CHK(fod_lim, 16'h8001)
        host.write_reg(8'hAC, 16'h1000);
        chk_rd(8'hAC, 16'h1000);
        `CHK(fod_lim, 16'h0400)
        $display("test fod done");
    endtask : test_fod

    // reset in mid-run while transmitting, rx power still above the reset split
    task automatic test_midrun_reset();
        host.send_command(16'h0001);
        `CHK(tx_mode, 1'b1)
        @(posedge sys_clk_i);
        nrst_i <= 1'b0;
        repeat (2) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        chk_rd(8'h98, 16'h2AF8);
        chk_rd(8'hAC, 16'h0E74);
        `CHK(fod_lim, 16'hFF9C)
        `CHK(tx_mode, 1'b0)
        $display("test midrun_reset done");
    endtask : test_midrun_reset

    task automatic end_of_test();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    // reset for 8 cycles, then the scenarios in turn
    initial begin
        repeat (8) @(posedge sys_clk_i);
        nrst_i <= 1'b1;
        test_reset_values();
        test_regs();
        test_reasons();
        test_commands();
        test_fod();
        test_midrun_reset();
        end_of_test();
    end

endmodule : wireless_tx_mode_register_bank_tb_top
